// [hw/mct_chan_cnt.sv]
// One channel counter with clear, preset, run gate and wrap pulses.
`timescale 1ns/10ps
module mct_chan_cnt
  import mct_pkg::*;
#(
  parameter int unsigned CW = MCT_CW
) (
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control.
  input  wire logic          run,
  input  wire logic          step,
  input  wire logic          up,
  input  wire logic          clr,
  input  wire logic          load,
  input  wire logic [CW-1:0] load_val,
  // Results.
  output logic      [CW-1:0] cnt,
  output logic               ovf,
  output logic               unf
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          ovf_r;
  logic          ovf_nxt;
  logic          unf_r;
  logic          unf_nxt;

  // ==========================================================================
  // Clear beats preset, preset beats counting, so a wrap never hides a clear.
  always_comb begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    unf_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0;
    end else if (load) begin
      cnt_nxt = load_val;
    end else if (run && step) begin
      if (up) begin
        cnt_nxt = cnt_r + 1'b1;
        ovf_nxt = &cnt_r;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
        unf_nxt = ~|cnt_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
    end
  end

  assign cnt = cnt_r;
  assign ovf = ovf_r;
  assign unf = unf_r;

endmodule : mct_chan_cnt

// [hw/mct_ctrl.sv]
// Common control of the multi_channel_timer: APB registers, sync logic, counters, interrupt.
`timescale 1ns/10ps
module mct_ctrl
  import mct_pkg::*;
#(
  parameter int unsigned CW = MCT_CW
) (
  // Clock and reset.
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave.
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Per-channel clear and preset requests from the channel logic.
  input  wire logic [MCT_NCH-1:0]        clr_req,
  input  wire logic [MCT_NCH-1:0]        preset_req,
  input  wire logic [CW-1:0]             preset_val,
  // Two-phase pins of channel 2.
  input  wire logic                      phase_a_pin,
  input  wire logic                      phase_b_pin,
  // Counter values and mode outputs.
  output logic      [MCT_NCH-1:0][CW-1:0] cnt_val,
  output logic      [MCT_NCH-1:0]        pulse_mode,
  output logic                           phase_count_select,
  output logic      [1:0]                combine_mode,
  output logic      [3:0]                buffer_enable,
  // Interrupt.
  output logic                           irq
);

  // ==========================================================================
  // Elaboration check.
  if (CW < 2 || CW > 32) begin : g_bad_width
    $error("mct_ctrl: counter width must be 2 to 32");
  end

  // ==========================================================================
  // Address decode and read value.
  function automatic logic [2:0] dec_addr(input logic [31:0] a);
    unique case (a)
      ADDR_RUN:  dec_addr = 3'h0;
      ADDR_SYNC: dec_addr = 3'h1;
      ADDR_MODE: dec_addr = 3'h2;
      ADDR_FUNC: dec_addr = 3'h3;
      ADDR_STAT: dec_addr = 3'h4;
      ADDR_MASK: dec_addr = 3'h5;
      default:   dec_addr = 3'h7;
    endcase
  endfunction : dec_addr

  // Forward order of {a,b} is 00, 10, 11, 01; one changed bit is one step.
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    quad_step = {^(prev ^ cur), ~(prev[1] ^ cur[0])};
  endfunction : quad_step

  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic [4:0] sync_r;
  logic [4:0] sync_nxt;
  logic [6:0] mode_r;
  logic [6:0] mode_nxt;
  logic [5:0] func_r;
  logic [5:0] func_nxt;
  logic [4:0] stat_r;
  logic [4:0] stat_nxt;
  logic [4:0] mask_r;
  logic [4:0] mask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [2:0]  sel;
  logic        wr_en;
  logic [7:0]  wd;

  assign sel   = dec_addr(paddr);
  assign wr_en = psel && penable && pready_r && pwrite;
  assign wd    = pwdata[7:0];

  // ==========================================================================
  // Pin synchronisers for the phase inputs.
  logic [1:0] ph_s1_r;
  logic [1:0] ph_s2_r;
  logic [1:0] ph_q_r;
  logic [1:0] qstep;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_s1_r <= 2'b00;
      ph_s2_r <= 2'b00;
      ph_q_r  <= 2'b00;
    end else begin
      ph_s1_r <= {phase_a_pin, phase_b_pin};
      ph_s2_r <= ph_s1_r;
      ph_q_r  <= ph_s2_r;
    end
  end

  assign qstep = quad_step(ph_q_r, ph_s2_r);

  // ==========================================================================
  // Synchronized preset and clear fan-out.
  logic [4:0] clr_eff;
  logic [4:0] load_eff;
  logic [4:0] step_en;
  logic [4:0] up_en;
  logic [4:0] ovf_w;
  logic [4:0] unf_w;
  logic [4:0] ev;

  always_comb begin
    for (int i = 0; i < MCT_NCH; i++) begin
      clr_eff[i]  = clr_req[i];
      load_eff[i] = preset_req[i];
      if (sync_r[i]) begin
        clr_eff[i]  = clr_req[i] || |(clr_req & sync_r);
        load_eff[i] = preset_req[i] || |(preset_req & sync_r);
      end
      step_en[i] = 1'b1;
      up_en[i]   = 1'b1;
    end
    if (mode_r[MODE_PHASE_BIT]) begin
      step_en[MCT_PHCH] = qstep[1];
      up_en[MCT_PHCH]   = qstep[0];
    end
  end

  for (genvar g = 0; g < MCT_NCH; g++) begin : g_ch
    mct_chan_cnt #(
      .CW(CW)
    ) u_cnt (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (run_r[g]),
      .step     (step_en[g]),
      .up       (up_en[g]),
      .clr      (clr_eff[g]),
      .load     (load_eff[g]),
      .load_val (preset_val),
      .cnt      (cnt_val[g]),
      .ovf      (ovf_w[g]),
      .unf      (unf_w[g])
    );
  end

  // ==========================================================================
  // Events and register next values.
  always_comb begin
    ev = ovf_w;
    ev[MCT_PHCH] = ovf_w[MCT_PHCH] || (!mode_r[MODE_FLAG_DIRECTION_SELECT_BIT] && unf_w[MCT_PHCH]);
  end

  always_comb begin
    run_nxt  = run_r;
    sync_nxt = sync_r;
    mode_nxt = mode_r;
    func_nxt = func_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_en) begin
      unique case (sel)
        3'h0:    run_nxt  = wd[4:0] & WM_RUN[4:0];
        3'h1:    sync_nxt = wd[4:0] & WM_SYNC[4:0];
        3'h2:    mode_nxt = wd[6:0] & WM_MODE[6:0];
        3'h3:    func_nxt = wd[5:0] & WM_FUNC[5:0];
        3'h4:    stat_nxt = stat_r & ~(wd[4:0] & WM_STAT[4:0]);
        3'h5:    mask_nxt = wd[4:0];
        default: run_nxt  = run_r;
      endcase
    end
    // A new event wins over a clearing write in the same cycle.
    stat_nxt = stat_nxt | ev;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  // ==========================================================================
  // APB answer: one wait-free access phase, data registered in setup.
  always_comb begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && (sel == 3'h7);
    prdata_nxt  = prdata_r;
    if (psel && !penable) begin
      unique case (sel)
        3'h0:    prdata_nxt = {24'h000000, FIX_RUN | {3'b000, run_r}};
        3'h1:    prdata_nxt = {24'h000000, FIX_SYNC | {3'b000, sync_r}};
        3'h2:    prdata_nxt = {24'h000000, FIX_MODE | {1'b0, mode_r}};
        3'h3:    prdata_nxt = {24'h000000, FIX_FUNC | {2'b00, func_r}};
        3'h4:    prdata_nxt = {27'h0000000, stat_r};
        3'h5:    prdata_nxt = {27'h0000000, mask_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r     <= RST_CTRL[4:0];
      sync_r    <= RST_CTRL[4:0];
      mode_r    <= RST_CTRL[6:0];
      func_r    <= RST_CTRL[5:0];
      stat_r    <= 5'h00;
      mask_r    <= 5'h00;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      run_r     <= run_nxt;
      sync_r    <= sync_nxt;
      mode_r    <= mode_nxt;
      func_r    <= func_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign irq                = irq_r;
  assign pulse_mode         = mode_r[4:0];
  assign phase_count_select = mode_r[MODE_PHASE_BIT];
  // combine field for channels 3 and 4.
  assign combine_mode       = func_r[FUNC_CMB_LSB+1:FUNC_CMB_LSB];
  assign buffer_enable      = func_r[3:0];

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_mode;
  logic wr_func;
  assign wr_mode = wr_en && (sel == 3'h2);
  assign wr_func = wr_en && (sel == 3'h3);

  sequence s_setup_run;
    psel && !penable && !pwrite && (sel == 3'h0);
  endsequence

  sequence s_read_fixed;
    ##1 pready && (prdata[7:5] == 3'b111) && (prdata[31:8] == 24'h000000);
  endsequence

  for (genvar k = 0; k < MCT_NCH; k++) begin : g_chk
    a_run_freeze: assert property (
      (!run_r[k] && !clr_eff[k] && !load_eff[k]) |=> $stable(cnt_val[k]))
      else $error("stopped counter moved");
    a_run_count: assert property (
      (run_r[k] && step_en[k] && up_en[k] && !clr_eff[k] && !load_eff[k])
      |=> cnt_val[k] == CW'($past(cnt_val[k]) + 1'b1))
      else $error("running counter did not advance");
  end

  a_indep_clear: assert property (
    (!sync_r[1] && !clr_req[1] && !preset_req[1] && !run_r[1] && |(clr_req | preset_req))
    |=> $stable(cnt_val[1]))
    else $error("independent channel disturbed");
  a_sync_clear: assert property (
    (sync_r[0] && sync_r[4] && (clr_req[0] || clr_req[4])) |=> (cnt_val[4] == '0) && (cnt_val[0] == '0))
    else $error("synchronized clear missed");
  a_sync_preset: assert property (
    (sync_r[0] && sync_r[4] && preset_req[0] && (clr_req == '0)) |=> cnt_val[4] == $past(preset_val))
    else $error("synchronized preset missed");
  a_phase_normal: assert property (
    (!mode_r[MODE_PHASE_BIT] && run_r[2] && !clr_eff[2] && !load_eff[2])
    |=> cnt_val[2] == CW'($past(cnt_val[2]) + 1'b1))
    else $error("channel 2 not counting normally");
  a_flag_under: assert property (
    (!mode_r[MODE_FLAG_DIRECTION_SELECT_BIT] && unf_w[2]) |=> stat_r[2])
    else $error("underflow flag missing");
  a_flag_over_only: assert property (
    (mode_r[MODE_FLAG_DIRECTION_SELECT_BIT] && unf_w[2] && !ovf_w[2] && !stat_r[2]) |=> !stat_r[2])
    else $error("underflow flagged with direction one");
  a_pulse_write: assert property (
    wr_mode |=> (pulse_mode == $past(pwdata[4:0])) && (phase_count_select == $past(pwdata[6])))
    else $error("mode write not applied");
  a_reset_zero: assert property (
    $rose(presetn) |-> (run_r == 5'h00) && (sync_r == 5'h00) && (mode_r == 7'h00))
    else $error("control not zero after reset");
  a_func_write: assert property (
    wr_func |=> (combine_mode == $past(pwdata[5:4])) && (buffer_enable == $past(pwdata[3:0])))
    else $error("function write not applied");
  a_fixed_read: assert property (
    s_setup_run |-> s_read_fixed)
    else $error("fixed read bits wrong");

endmodule : mct_ctrl

// [hw/mct_pkg.sv]
// Constants, register map and field layout of the multi_channel_timer common control.
package mct_pkg;

  // ==========================================================================
  // Sizes.
  localparam int unsigned MCT_NCH  = 5;
  localparam int unsigned MCT_CW   = 16;
  localparam int unsigned MCT_PHCH = 2;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [29:0] IDX_RUN  = 30'h05FFFF00;
  localparam logic [29:0] IDX_SYNC = 30'h05FFFF01;
  localparam logic [29:0] IDX_MODE = 30'h05FFFF02;
  localparam logic [29:0] IDX_FUNC = 30'h05FFFF03;
  localparam logic [29:0] IDX_STAT = 30'h05FFFF40;
  localparam logic [29:0] IDX_MASK = 30'h05FFFF41;

  localparam logic [31:0] ADDR_RUN  = {IDX_RUN, 2'b00};
  localparam logic [31:0] ADDR_SYNC = {IDX_SYNC, 2'b00};
  localparam logic [31:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [31:0] ADDR_FUNC = {IDX_FUNC, 2'b00};
  localparam logic [31:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [31:0] ADDR_MASK = {IDX_MASK, 2'b00};

  // ==========================================================================
  // Field positions, writable masks, fixed read bits and reset values.
  localparam int unsigned MODE_PHASE_BIT = 6;
  localparam int unsigned MODE_FLAG_DIRECTION_SELECT_BIT  = 5;
  localparam int unsigned FUNC_CMB_LSB   = 4;

  localparam logic [7:0] WM_RUN  = 8'h1F;
  localparam logic [7:0] WM_SYNC = 8'h1F;
  localparam logic [7:0] WM_MODE = 8'h7F;
  localparam logic [7:0] WM_FUNC = 8'h3F;
  localparam logic [7:0] WM_STAT = 8'h1F;

  localparam logic [7:0] FIX_RUN  = 8'hE0;
  localparam logic [7:0] FIX_SYNC = 8'hE0;
  localparam logic [7:0] FIX_MODE = 8'h80;
  localparam logic [7:0] FIX_FUNC = 8'hC0;

  localparam logic [7:0] RST_CTRL = 8'h00;

  // ==========================================================================
  // Combination modes of channels 3 and 4.
  typedef enum logic [1:0] {
    CMB_NORM0 = 2'b00,
    CMB_NORM1 = 2'b01,
    CMB_COMPL = 2'b10,
    CMB_RSYNC = 2'b11
  } mct_cmb_t;

endpackage : mct_pkg

// [test/mct_ctrl_bench.sv]
// Self-checking testbench of the multi_channel_timer common control.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %h expected %h", $time, (got), (exp)); end end
module mct_ctrl_bench;
  import mct_pkg::*;

  // ==========================================================================
  // Stimulus and design.
  typedef struct {logic [31:0] a; logic [7:0] w; logic [7:0] r;} mct_row_t;
  logic                        pclk = 1'b0, presetn = 1'b0;
  logic                        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]                 paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic                        pready, pslverr, er, irq, phase_count_select;
  logic [MCT_NCH-1:0]          clr_req = 5'h00, preset_req = 5'h00, pulse_mode;
  logic [MCT_CW-1:0]           preset_val = 16'h0000;
  logic                        phase_a_pin = 1'b0, phase_b_pin = 1'b0;
  logic [MCT_NCH-1:0][MCT_CW-1:0] cnt_val;
  logic [1:0]                  combine_mode;
  logic [3:0]                  buffer_enable;
  logic [MCT_CW-1:0]           snap;
  int                          error_cnt = 0, checks_done = 0;
  mct_row_t                    rows[10];

  mct_ctrl i_mct_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clr_req(clr_req),
    .preset_req(preset_req), .preset_val(preset_val), .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin),
    .cnt_val(cnt_val), .pulse_mode(pulse_mode), .phase_count_select(phase_count_select),
    .combine_mode(combine_mode), .buffer_enable(buffer_enable), .irq(irq));

  initial begin
    forever #25 pclk = ~pclk;
  end

  // ==========================================================================
  // Tasks.
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // One APB transfer, entered just after a rising edge with the bus idle.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One-cycle clear and preset requests; the idle edge after lets the counter land.
  task automatic req(input logic [4:0] c, input logic [4:0] p, input logic [15:0] v);
    clr_req <= c;
    preset_req <= p;
    preset_val <= v;
    @(posedge pclk);
    clr_req <= 5'h00;
    preset_req <= 5'h00;
    @(posedge pclk);
  endtask : req

  // ==========================================================================
  // Main sequence.
  initial begin
    rows = '{'{ADDR_RUN, 8'hE0, 8'hE0}, '{ADDR_SYNC, 8'hEA, 8'hEA}, '{ADDR_SYNC, 8'h00, 8'hE0},
             '{ADDR_MODE, 8'hFF, 8'hFF}, '{ADDR_MODE, 8'h00, 8'h80}, '{ADDR_FUNC, 8'hD5, 8'hD5},
             '{ADDR_FUNC, 8'h3F, 8'hFF}, '{ADDR_FUNC, 8'h00, 8'hC0}, '{ADDR_MASK, 8'hFF, 8'h1F},
             '{ADDR_MASK, 8'h00, 8'h00}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_RUN, 8'h00);  `CHK(rd[7:0], 8'hE0) // run bits clear
    apb(1'b0, ADDR_SYNC, 8'h00); `CHK(rd[7:0], 8'hE0) // sync bits clear
    apb(1'b0, ADDR_MODE, 8'h00); `CHK(rd[7:0], 8'h80) // mode bits clear
    apb(1'b0, ADDR_FUNC, 8'h00); `CHK(rd[7:0], 8'hC0) // function reset
    `CHK(cnt_val, 80'h0) // counters stopped
    $display("reset test done");
    // Writes are read back with the fixed bits merged in.
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 8'h00);
      `CHK(rd, {24'h000000, rows[i].r}) // fixed unused bits
    end
    $display("register table done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_MODE, 8'(1 << i));
      `CHK(pulse_mode, 5'(1 << i)) // pulse mode per channel
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_FUNC, {2'b00, 2'(m), 4'(1 << m)});
      `CHK(combine_mode, 2'(m)) // combine codes
      `CHK(buffer_enable, 4'(1 << m)) // buffer enables
    end
    apb(1'b1, ADDR_MODE, 8'h40);
    `CHK(phase_count_select, 1'b1) // phase select output
    apb(1'b0, 32'h00000000, 8'h00);
    `CHK(er, 1'b1) // unmapped address refused
    `CHK(rd, 32'h0) // unmapped read zero
    $display("mode output test done");
    apb(1'b1, ADDR_MODE, 8'h00);
    // Only the running channels advance, in step.
    apb(1'b1, ADDR_RUN, 8'h05);
    repeat (10) @(posedge pclk);
    apb(1'b1, ADDR_RUN, 8'h00);
    snap = cnt_val[0];
    repeat (5) @(posedge pclk);
    `CHK(cnt_val[0], snap) // stopped counter frozen
    `CHK(cnt_val[2], snap) // channels start together
    `CHK(cnt_val[1], 16'h0000) // idle channel frozen
    `CHK(snap == 16'h0000, 1'b0) // running channel advanced
    $display("run test done");
    // Overflow flag with the mask closed, then opened, then cleared.
    req(5'h00, 5'h01, 16'hFFFE);
    apb(1'b1, ADDR_RUN, 8'h01);
    repeat (4) @(posedge pclk);
    apb(1'b1, ADDR_RUN, 8'h00);
    `CHK(irq, 1'b0) // masked flag quiet
    apb(1'b0, ADDR_STAT, 8'h00); `CHK(rd[4:0], 5'h01) // overflow flag set
    apb(1'b1, ADDR_MASK, 8'h01); `CHK(irq, 1'b1) // unmasked flag raises interrupt
    apb(1'b1, ADDR_STAT, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b0) // cleared flag drops interrupt
    $display("overflow test done");
    // Channel 2 in phase mode steps down through zero by pin changes only.
    apb(1'b1, ADDR_MASK, 8'h04);
    apb(1'b1, ADDR_MODE, 8'h40);
    req(5'h00, 5'h04, 16'h0000);
    apb(1'b1, ADDR_RUN, 8'h04);
    phase_b_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(cnt_val[2], 16'hFFFF) // one step down per pin change
    apb(1'b0, ADDR_STAT, 8'h00); `CHK(rd[2], 1'b1) // underflow flagged
    `CHK(irq, 1'b1) // underflow interrupt
    apb(1'b1, ADDR_STAT, 8'h04);
    apb(1'b1, ADDR_MODE, 8'h60);
    req(5'h00, 5'h04, 16'h0000);
    phase_a_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(cnt_val[2], 16'hFFFF) // second down step
    apb(1'b0, ADDR_STAT, 8'h00); `CHK(rd[2], 1'b0) // underflow ignored with direction set
    apb(1'b1, ADDR_MODE, 8'h00);
    repeat (4) @(posedge pclk);
    `CHK(cnt_val[2] == 16'hFFFF, 1'b0) // normal counting restored
    apb(1'b1, ADDR_RUN, 8'h00);
    $display("phase test done");
    // Channels 0 and 4 synchronized, channel 1 and 3 independent.
    apb(1'b1, ADDR_SYNC, 8'h11);
    req(5'h00, 5'h01, 16'h1234);
    `CHK(cnt_val[4], 16'h1234) // synchronized preset
    `CHK(cnt_val[3], 16'h0000) // independent channel untouched
    req(5'h00, 5'h02, 16'h0055);
    `CHK(cnt_val[0], 16'h1234) // independent preset stays local
    req(5'h02, 5'h00, 16'h0000);
    `CHK(cnt_val[1], 16'h0000) // independent clear
    `CHK(cnt_val[4], 16'h1234) // synchronized channel kept
    req(5'h00, 5'h02, 16'h0055);
    req(5'h10, 5'h00, 16'h0000);
    `CHK(cnt_val[0], 16'h0000) // synchronized clear
    `CHK(cnt_val[1], 16'h0055) // synchronized clear stays out
    $display("sync test done");
    // A second reset in mid-run returns every mode to zero.
    apb(1'b1, ADDR_MODE, 8'h7F);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(pulse_mode, 5'h00) // pulse modes cleared
    apb(1'b0, ADDR_MODE, 8'h00); `CHK(rd[7:0], 8'h80) // mode register cleared
    $display("second reset test done");
    summarize();
  end
endmodule : mct_ctrl_bench
